// ===== inc/cctdp_pkg.sv
// constants, field layouts and types for the cycle timing and dual pointer block
package cctdp_pkg;

  // register indices; byte address is four times the index
  localparam logic [9:0] IDX_INSTR  = 10'h000;
  localparam logic [9:0] IDX_OPND   = 10'h001;
  localparam logic [9:0] IDX_FLAGS  = 10'h002;
  localparam logic [9:0] IDX_STATUS = 10'h003;
  localparam logic [9:0] IDX_PRIM   = 10'h004;
  localparam logic [9:0] IDX_SEC    = 10'h005;
  localparam logic [9:0] IDX_PORT2  = 10'h006;
  localparam logic [9:0] IDX_IWREG  = 10'h007;
  localparam logic [9:0] IDX_ACTIVE = 10'h008;
  localparam logic [9:0] IDX_SELECT = 10'h086;
  localparam logic [9:0] IDX_CLKCTL = 10'h08E;

  // timing
  localparam logic [1:0] STATE_LAST       = 2'h3;
  localparam logic [2:0] STRETCH_RST      = 3'h1;
  localparam logic [3:0] EXTERNAL_DATA_MOVE_BASE_CYCLES = 4'h2;
  localparam logic [3:0] MIN_MULTI_CYCLES = 4'h2;
  localparam logic [3:0] LONG_OP_CYCLES   = 4'h5;
  localparam logic [5:0] STRB_MIN_CLKS    = 6'h02;
  localparam logic [5:0] STRB_START_FAST  = 6'h05;
  localparam logic [5:0] STRB_START       = 6'h06;

  // flag register bit positions
  localparam int FLAG_CY = 0;
  localparam int FLAG_AC = 1;
  localparam int FLAG_OV = 2;

  typedef enum logic [1:0] {
    K_PLAIN    = 2'h0,
    K_EXTERNAL_DATA_MOVE_RI  = 2'h1,
    K_EXTERNAL_DATA_MOVE_PTR = 2'h2,
    K_INC_SEL  = 2'h3
  } cctdp_kind_e;

  typedef enum logic [3:0] {
    F_NONE = 4'h0, F_ADD  = 4'h1, F_ADD_WITH_CARRY = 4'h2, F_SUBTRACT_WITH_BORROW = 4'h3,
    F_MUL  = 4'h4, F_DIV  = 4'h5, F_DA   = 4'h6, F_RRC  = 4'h7,
    F_RLC  = 4'h8, F_SETC = 4'h9, F_CLRC = 4'hA, F_CPLC = 4'hB,
    F_ANLC = 4'hC, F_ORLC = 4'hD, F_MOVC = 4'hE, F_COMPARE_JUMP_NOT_EQUAL = 4'hF
  } cctdp_fop_e;

  // instruction register layout, lsb is the opcode
  typedef struct packed {
    cctdp_fop_e  fop;
    logic        wr_dir;
    cctdp_kind_e kind;
    logic        branch;
    logic [1:0]  bytes;
    logic [7:0]  opcode;
  } cctdp_instr_s;

  // operand register layout
  typedef struct packed {
    logic       bit_in;
    logic [7:0] src;
    logic [7:0] acc;
  } cctdp_opnd_s;

  typedef enum logic {S_IDLE, S_RUN} cctdp_seq_e;

endpackage

// ===== hw/cctdp_core.sv
// cycle timing sequencer, flag unit, dual data pointer and stretched external move
`timescale 1ns/10ps
module cctdp_core (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // sequencing
  output logic [1:0]       mc_state,
  output logic             fetch_stb,
  output logic             busy,
  // external data memory
  output logic [15:0]      ext_addr,
  output logic [7:0]       ext_wdata,
  output logic             ext_rd_n,
  output logic             ext_wr_n,
  input  wire logic [7:0]  ext_rdata
);

  cctdp_pkg::cctdp_seq_e   seq_ff;
  cctdp_pkg::cctdp_instr_s instr_ff;
  cctdp_pkg::cctdp_opnd_s  opnd_ff;
  logic [1:0]  state_ff;
  logic [3:0]  cyc_ff, total_ff, last_total_ff;
  logic        pend_ff;
  logic [2:0]  flags_ff, nxt_flags;
  logic [15:0] prim_ff, sec_ff;
  logic [7:0]  port2_ff, iwreg_ff, rdata_ff;
  logic        sel_ff;
  logic [2:0]  stretch_ff;
  logic        rd_n_ff, wr_n_ff;
  logic [15:0] addr_ff;
  logic [7:0]  wdata_ff;
  logic [7:0]  rsync1_ff, rsync2_ff, rsync3_ff;
  logic [31:0] prdata_ff, rmux;
  logic        pslverr_ff, mapped;
  logic        wr_acc, start, done, is_external_data_move, strb_win;
  logic [9:0]  idx;
  logic [5:0]  clk_idx, strb_w, strb_s;

  // cycles of one instruction from its descriptor and the stretch field
  function automatic logic [3:0] cycles_of(input cctdp_pkg::cctdp_instr_s i,
                                           input logic [2:0] s);
    logic [3:0] n;
    n = {2'h0, i.bytes} + {3'h0, i.branch};
    if (i.kind == cctdp_pkg::K_EXTERNAL_DATA_MOVE_RI || i.kind == cctdp_pkg::K_EXTERNAL_DATA_MOVE_PTR) begin
      n = cctdp_pkg::EXTERNAL_DATA_MOVE_BASE_CYCLES + {1'b0, s};
    end else if (i.opcode[3]) begin
      n = 4'h1;
    end else if (i.fop == cctdp_pkg::F_MUL || i.fop == cctdp_pkg::F_DIV) begin
      n = cctdp_pkg::LONG_OP_CYCLES;
    end else if (n < cctdp_pkg::MIN_MULTI_CYCLES) begin
      n = cctdp_pkg::MIN_MULTI_CYCLES;
    end
    return n;
  endfunction

  // ---------------- apb slave ----------------
  assign idx     = paddr[11:2];
  assign wr_acc  = psel & penable & pwrite;
  assign pready  = 1'b1;
  assign prdata  = prdata_ff;
  assign pslverr = pslverr_ff;

  always_comb begin
    mapped = 1'b1;
    rmux   = 32'h0000_0000;
    case (idx)
      cctdp_pkg::IDX_INSTR:  rmux = {14'h0000, instr_ff};
      cctdp_pkg::IDX_OPND:   rmux = {15'h0000, opnd_ff};
      cctdp_pkg::IDX_FLAGS:  rmux = {29'h0000_0000, flags_ff};
      cctdp_pkg::IDX_STATUS: rmux = {16'h0000, rdata_ff, last_total_ff, state_ff, pend_ff,
                                     (seq_ff == cctdp_pkg::S_RUN)};
      cctdp_pkg::IDX_PRIM:   rmux = {16'h0000, prim_ff};
      cctdp_pkg::IDX_SEC:    rmux = {16'h0000, sec_ff};
      cctdp_pkg::IDX_PORT2:  rmux = {24'h00_0000, port2_ff};
      cctdp_pkg::IDX_IWREG:  rmux = {24'h00_0000, iwreg_ff};
      cctdp_pkg::IDX_ACTIVE: rmux = {16'h0000, sel_ff ? sec_ff : prim_ff};
      cctdp_pkg::IDX_SELECT: rmux = {31'h0000_0000, sel_ff};
      cctdp_pkg::IDX_CLKCTL: rmux = {29'h0000_0000, stretch_ff};
      default:               mapped = 1'b0;
    endcase
  end

  // read data latched in the setup phase so the access phase answers at once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff  <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end else if (psel && !penable) begin
      prdata_ff  <= pwrite ? 32'h0000_0000 : rmux;
      pslverr_ff <= ~mapped;
    end
  end

  // ---------------- software registers ----------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      opnd_ff    <= '0;
      port2_ff   <= 8'hFF;
      iwreg_ff   <= 8'h00;
      stretch_ff <= cctdp_pkg::STRETCH_RST;
    end else if (wr_acc) begin
      case (idx)
        cctdp_pkg::IDX_OPND:   opnd_ff    <= pwdata[16:0];
        cctdp_pkg::IDX_PORT2:  port2_ff   <= pwdata[7:0];
        cctdp_pkg::IDX_IWREG:  iwreg_ff   <= pwdata[7:0];
        cctdp_pkg::IDX_CLKCTL: stretch_ff <= pwdata[2:0];
        default: ;
      endcase
    end
  end

  // pointers; writes through the active alias follow the select bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prim_ff <= 16'h0000;
      sec_ff  <= 16'h0000;
    end else if (wr_acc) begin
      if (idx == cctdp_pkg::IDX_PRIM || (idx == cctdp_pkg::IDX_ACTIVE && !sel_ff)) begin
        prim_ff <= pwdata[15:0];
      end
      if (idx == cctdp_pkg::IDX_SEC || (idx == cctdp_pkg::IDX_ACTIVE && sel_ff)) begin
        sec_ff <= pwdata[15:0];
      end
    end
  end

  // the increment toggle wins over a software write in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_ff <= 1'b0;
    end else if (done && instr_ff.kind == cctdp_pkg::K_INC_SEL) begin
      sel_ff <= ~sel_ff;
    end else if (wr_acc && idx == cctdp_pkg::IDX_SELECT) begin
      sel_ff <= pwdata[0];
    end
  end

  // ---------------- sequencer ----------------
  // one edge per state: mid-state work is registered on the same rising edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= 2'h0;
    end else begin
      state_ff <= state_ff + 2'h1;
    end
  end

  assign start   = pend_ff && state_ff == cctdp_pkg::STATE_LAST;
  assign done    = seq_ff == cctdp_pkg::S_RUN && state_ff == cctdp_pkg::STATE_LAST &&
                   cyc_ff == total_ff - 4'h1;
  assign is_external_data_move = instr_ff.kind == cctdp_pkg::K_EXTERNAL_DATA_MOVE_RI ||
                   instr_ff.kind == cctdp_pkg::K_EXTERNAL_DATA_MOVE_PTR;

  // a new descriptor is refused while one is pending or running
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_ff  <= 1'b0;
      instr_ff <= '0;
    end else if (wr_acc && idx == cctdp_pkg::IDX_INSTR && !pend_ff &&
                 seq_ff == cctdp_pkg::S_IDLE) begin
      pend_ff  <= 1'b1;
      instr_ff <= pwdata[17:0];
    end else if (start) begin
      pend_ff <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seq_ff        <= cctdp_pkg::S_IDLE;
      cyc_ff        <= 4'h0;
      total_ff      <= 4'h1;
      last_total_ff <= 4'h0;
    end else begin
      case (seq_ff)
        cctdp_pkg::S_IDLE: begin
          if (start) begin
            seq_ff   <= cctdp_pkg::S_RUN;
            cyc_ff   <= 4'h0;
            total_ff <= cycles_of(instr_ff, stretch_ff);
          end
        end
        cctdp_pkg::S_RUN: begin
          if (done) begin
            seq_ff        <= cctdp_pkg::S_IDLE;
            last_total_ff <= total_ff;
          end else if (state_ff == cctdp_pkg::STATE_LAST) begin
            cyc_ff <= cyc_ff + 4'h1;
          end
        end
        default: seq_ff <= cctdp_pkg::S_IDLE;
      endcase
    end
  end

  assign mc_state = state_ff;
  assign busy     = pend_ff | (seq_ff == cctdp_pkg::S_RUN);
  // fetches only in the first state: once for a single-cycle opcode, else while bytes remain
  assign fetch_stb = seq_ff == cctdp_pkg::S_RUN && state_ff == 2'h0 &&
                     (total_ff == 4'h1 ? cyc_ff == 4'h0 : cyc_ff < {2'h0, instr_ff.bytes});

  // ---------------- flag unit ----------------
  always_comb begin
    logic [8:0]  s9;
    logic [4:0]  n5;
    logic [15:0] p16;
    logic [7:0]  a, b, t;
    logic        c;
    a = opnd_ff.acc;
    b = opnd_ff.src;
    c = flags_ff[cctdp_pkg::FLAG_CY];
    s9 = 9'h000;
    n5 = 5'h00;
    p16 = 16'h0000;
    t = 8'h00;
    nxt_flags = flags_ff;
    case (instr_ff.fop)
      cctdp_pkg::F_ADD, cctdp_pkg::F_ADD_WITH_CARRY: begin
        c   = (instr_ff.fop == cctdp_pkg::F_ADD_WITH_CARRY) & c;
        s9  = {1'b0, a} + {1'b0, b} + {8'h00, c};
        n5  = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, c};
        nxt_flags = {(a[7] == b[7]) && (s9[7] != a[7]), n5[4], s9[8]};
      end
      cctdp_pkg::F_SUBTRACT_WITH_BORROW: begin
        s9  = {1'b0, a} - {1'b0, b} - {8'h00, c};
        n5  = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, c};
        nxt_flags = {(a[7] != b[7]) && (s9[7] != a[7]), n5[4], s9[8]};
      end
      cctdp_pkg::F_MUL: begin
        p16 = a * b;
        nxt_flags[cctdp_pkg::FLAG_OV] = |p16[15:8];
        nxt_flags[cctdp_pkg::FLAG_CY] = 1'b0;
      end
      cctdp_pkg::F_DIV: begin
        nxt_flags[cctdp_pkg::FLAG_OV] = (b == 8'h00);
        nxt_flags[cctdp_pkg::FLAG_CY] = 1'b0;
      end
      cctdp_pkg::F_DA: begin
        t  = (flags_ff[cctdp_pkg::FLAG_AC] || a[3:0] > 4'h9) ? 8'h06 : 8'h00;
        s9 = {1'b0, a} + {1'b0, t};
        nxt_flags[cctdp_pkg::FLAG_CY] = c | s9[8] | (s9[7:4] > 4'h9);
      end
      cctdp_pkg::F_RRC:  nxt_flags[cctdp_pkg::FLAG_CY] = a[0];
      cctdp_pkg::F_RLC:  nxt_flags[cctdp_pkg::FLAG_CY] = a[7];
      cctdp_pkg::F_SETC: nxt_flags[cctdp_pkg::FLAG_CY] = 1'b1;
      cctdp_pkg::F_CLRC: nxt_flags[cctdp_pkg::FLAG_CY] = 1'b0;
      cctdp_pkg::F_CPLC: nxt_flags[cctdp_pkg::FLAG_CY] = ~c;
      cctdp_pkg::F_ANLC: nxt_flags[cctdp_pkg::FLAG_CY] = c & opnd_ff.bit_in;
      cctdp_pkg::F_ORLC: nxt_flags[cctdp_pkg::FLAG_CY] = c | opnd_ff.bit_in;
      cctdp_pkg::F_MOVC: nxt_flags[cctdp_pkg::FLAG_CY] = opnd_ff.bit_in;
      cctdp_pkg::F_COMPARE_JUMP_NOT_EQUAL: nxt_flags[cctdp_pkg::FLAG_CY] = a < b;
      default: ;
    endcase
  end

  // hardware update at completion wins over a software write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_ff <= 3'h0;
    end else if (done) begin
      flags_ff <= nxt_flags;
    end else if (wr_acc && idx == cctdp_pkg::IDX_FLAGS) begin
      flags_ff <= pwdata[2:0];
    end
  end

  // ---------------- external data move ----------------
  assign clk_idx = {cyc_ff, state_ff};
  assign strb_w  = (stretch_ff == 3'h0) ? cctdp_pkg::STRB_MIN_CLKS : {1'b0, stretch_ff, 2'b00};
  assign strb_s  = (stretch_ff == 3'h0) ? cctdp_pkg::STRB_START_FAST : cctdp_pkg::STRB_START;
  assign strb_win = seq_ff == cctdp_pkg::S_RUN && is_external_data_move &&
                    clk_idx >= strb_s && clk_idx < strb_s + strb_w;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_ff  <= 16'h0000;
      wdata_ff <= 8'h00;
    end else if (start) begin
      wdata_ff <= opnd_ff.acc;
      if (instr_ff.kind == cctdp_pkg::K_EXTERNAL_DATA_MOVE_RI) begin
        addr_ff <= {port2_ff, iwreg_ff};
      end else if (instr_ff.kind == cctdp_pkg::K_EXTERNAL_DATA_MOVE_PTR) begin
        addr_ff <= sel_ff ? sec_ff : prim_ff;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_n_ff <= 1'b1;
      wr_n_ff <= 1'b1;
    end else begin
      rd_n_ff <= ~(strb_win & ~instr_ff.wr_dir);
      wr_n_ff <= ~(strb_win & instr_ff.wr_dir);
    end
  end

  // read data is a pin input: three stages, taken once the last two agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rsync1_ff <= 8'h00;
      rsync2_ff <= 8'h00;
      rsync3_ff <= 8'h00;
    end else begin
      rsync1_ff <= ext_rdata;
      rsync2_ff <= rsync1_ff;
      rsync3_ff <= rsync2_ff;
    end
  end

  // read strobe delayed to line up with the synchroniser stages
  logic rdq1_ff, rdq2_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdq1_ff <= 1'b0;
      rdq2_ff <= 1'b0;
    end else begin
      rdq1_ff <= ~rd_n_ff;
      rdq2_ff <= rdq1_ff;
    end
  end

  // taken two clocks after the strobe ends, when the last two stages hold the
  // last two strobe clocks; this still works for the shortest two-clock strobe
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_ff <= 8'h00;
    end else if (rdq2_ff && !rdq1_ff && rsync2_ff == rsync3_ff) begin
      rdata_ff <= rsync3_ff;
    end
  end

  assign ext_addr  = addr_ff;
  assign ext_wdata = wdata_ff;
  assign ext_rd_n  = rd_n_ff;
  assign ext_wr_n  = wr_n_ff;

  // ---------------- assertions ----------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic [5:0] strb_len_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strb_len_ff <= 6'h00;
    end else begin
      strb_len_ff <= (!rd_n_ff || !wr_n_ff) ? strb_len_ff + 6'h01 : 6'h00;
    end
  end

  sequence s_c1_to_c4;
    state_ff == 2'h0 ##1 state_ff == 2'h1 ##1 state_ff == 2'h2 ##1 state_ff == 2'h3;
  endsequence
  property p_state_order;
    state_ff == 2'h0 |-> s_c1_to_c4 ##1 state_ff == 2'h0;
  endproperty
  a_state_order: assert property (p_state_order) else $error("state order broken");
  property p_fetch_once;
    fetch_stb |-> state_ff == 2'h0 ##1 !fetch_stb [*3];
  endproperty
  a_fetch_once: assert property (p_fetch_once) else $error("two fetches in a cycle");
  property p_single;
    start && instr_ff.opcode[3] && !is_external_data_move |=> total_ff == 4'h1;
  endproperty
  a_single: assert property (p_single) else $error("single cycle opcode wrong");
  property p_multi;
    seq_ff == cctdp_pkg::S_RUN && !instr_ff.opcode[3] && !is_external_data_move |->
      total_ff >= 4'h2 && total_ff <= 4'h5;
  endproperty
  a_multi: assert property (p_multi) else $error("cycle count out of range");
  property p_external_data_move_len;
    start && is_external_data_move |=> total_ff == 4'h2 + {1'b0, $past(stretch_ff)};
  endproperty
  a_external_data_move_len: assert property (p_external_data_move_len) else $error("external move length wrong");
  property p_strobe_width;
    $rose(rd_n_ff & wr_n_ff) |->
      strb_len_ff == ((stretch_ff == 3'h0) ? 6'h02 : {1'b0, stretch_ff, 2'b00});
  endproperty
  a_strobe_width: assert property (p_strobe_width) else $error("strobe width wrong");
  property p_ri_addr;
    start && instr_ff.kind == cctdp_pkg::K_EXTERNAL_DATA_MOVE_RI |=>
      ext_addr == {$past(port2_ff), $past(iwreg_ff)};
  endproperty
  a_ri_addr: assert property (p_ri_addr) else $error("indirect address wrong");
  property p_ptr_addr;
    start && instr_ff.kind == cctdp_pkg::K_EXTERNAL_DATA_MOVE_PTR |=>
      ext_addr == ($past(sel_ff) ? $past(sec_ff) : $past(prim_ff));
  endproperty
  a_ptr_addr: assert property (p_ptr_addr) else $error("pointer address wrong");
  property p_inc_toggle;
    done && instr_ff.kind == cctdp_pkg::K_INC_SEL |=> sel_ff != $past(sel_ff);
  endproperty
  a_inc_toggle: assert property (p_inc_toggle) else $error("select not toggled");
  property p_carry_clear;
    done && (instr_ff.fop == cctdp_pkg::F_MUL || instr_ff.fop == cctdp_pkg::F_CLRC) |=>
      !flags_ff[0];
  endproperty
  a_carry_clear: assert property (p_carry_clear) else $error("carry not cleared");

endmodule

// ===== sim/cctdp_extmem.sv
// external data memory model on the far side of the stretched move path
`timescale 1ns/10ps
module cctdp_extmem (
  // clock
  input  wire logic        pclk,
  // memory pins
  input  wire logic [15:0] ext_addr,
  input  wire logic [7:0]  ext_wdata,
  input  wire logic        ext_rd_n,
  input  wire logic        ext_wr_n,
  output logic [7:0]       ext_rdata,
  // observation for the bench
  output logic [15:0]      seen_addr,
  output logic [7:0]       seen_wdata,
  output int               seen_width
);
  logic [7:0] mem [256];
  logic [7:0] last_ff;
  int         cnt;

  initial begin
    for (int i = 0; i < 256; i++) mem[i] = 8'hA5 ^ 8'(i);
    last_ff = 8'h00;
    cnt = 0;
    seen_width = 0;
    seen_addr = 16'h0000;
    seen_wdata = 8'h00;
  end

  // released bus shows the inverse of the last value, so stale data never matches
  assign ext_rdata = ext_rd_n ? ~last_ff : mem[ext_addr[7:0]];

  always @(posedge pclk) begin
    if (!ext_rd_n || !ext_wr_n) begin
      cnt = cnt + 1;
      seen_addr <= ext_addr;
    end else if (cnt != 0) begin
      seen_width = cnt;
      cnt = 0;
    end
    if (!ext_rd_n) last_ff <= mem[ext_addr[7:0]];
    if (!ext_wr_n) begin
      mem[ext_addr[7:0]] <= ext_wdata;
      seen_wdata <= ext_wdata;
    end
  end
endmodule

// ===== sim/cctdp_core_tb.sv
// self-checking bench for the cycle timing and dual pointer block
`timescale 1ns/10ps
module cctdp_core_tb;
  logic        pclk = 1'b0;
  logic        presetn, psel, penable, pwrite, pready, pslverr, fetch_stb, busy;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rv, st;
  logic [1:0]  mc_state, p;
  logic [15:0] ext_addr, seen_addr;
  logic [7:0]  ext_wdata, ext_rdata, seen_wdata;
  logic        ext_rd_n, ext_wr_n, err;
  int          seen_width;
  int          fails = 0;
  int          num_checks = 0;
  int          fetches = 0;

  always #50 pclk = ~pclk;

  // fetch pulses seen during one instruction
  always @(posedge pclk) if (fetch_stb === 1'b1) fetches <= fetches + 1;

  cctdp_core uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mc_state(mc_state), .fetch_stb(fetch_stb), .busy(busy),
    .ext_addr(ext_addr), .ext_wdata(ext_wdata), .ext_rd_n(ext_rd_n),
    .ext_wr_n(ext_wr_n), .ext_rdata(ext_rdata));

  cctdp_extmem mem_model (.pclk(pclk), .ext_addr(ext_addr), .ext_wdata(ext_wdata),
    .ext_rd_n(ext_rd_n), .ext_wr_n(ext_wr_n), .ext_rdata(ext_rdata),
    .seen_addr(seen_addr), .seen_wdata(seen_wdata), .seen_width(seen_width));

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  // one apb transfer; the request holds until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin fails++; tally_and_finish(); end
    rv = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task automatic wr(input logic [9:0] idx, input logic [31:0] d);
    apb(1'b1, {idx, 2'b00}, d);
  endtask

  task automatic rd(input logic [9:0] idx);
    apb(1'b0, {idx, 2'b00}, 32'h0000_0000);
  endtask

  // instruction word: flag op, direction, kind, branch, bytes, opcode
  function automatic logic [31:0] ins(input logic [3:0] f, input logic w,
      input logic [1:0] k, input logic b, input logic [1:0] nb, input logic [7:0] op);
    return {14'h0000, f, w, k, b, nb, op};
  endfunction

  task automatic run(input logic [31:0] i);
    int n;
    fetches = 0;
    wr(cctdp_pkg::IDX_INSTR, i);
    n = 0;
    do begin @(posedge pclk); n++; end while (busy !== 1'b0 && n < 200);
    if (busy !== 1'b0) begin fails++; tally_and_finish(); end
    rd(cctdp_pkg::IDX_STATUS);
    st = rv;
  endtask

  logic [31:0] cyc_ins [5];
  logic [3:0]  cyc_exp [5];

  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 12'h000; pwdata = 32'h0000_0000;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rd(cctdp_pkg::IDX_SELECT);
    chk("select_reset", 32'h0000_0000, rv);
    rd(cctdp_pkg::IDX_CLKCTL);
    chk("stretch_reset", 32'h0000_0001, rv & 32'h0000_0007);
    apb(1'b0, 12'hFFC, 32'h0000_0000);
    chk("unmapped_err", 32'h0000_0001, {31'h0, err});
    @(posedge pclk);
    p = mc_state;
    repeat (8) begin
      @(posedge pclk);
      chk("mc_state", {30'h0, p + 2'h1}, {30'h0, mc_state});
      p = mc_state;
    end
    $display("test reset_and_states done");

    wr(cctdp_pkg::IDX_PORT2, 32'h0000_0012);
    for (int s = 0; s < 8; s++) begin
      wr(cctdp_pkg::IDX_CLKCTL, 32'(s));
      wr(cctdp_pkg::IDX_IWREG, 32'(8'h40 + s));
      run(ins(4'h0, 1'b0, 2'h1, 1'b0, 2'h1, 8'h00));
      chk("move_cycles", 32'(2 + s), {28'h0, st[7:4]});
      chk("strobe_width", 32'((s == 0) ? 2 : 4 * s), 32'(seen_width));
      chk("ri_addr", {16'h0, 8'h12, 8'(8'h40 + s)}, {16'h0, seen_addr});
      chk("read_data", {24'h0, 8'hA5 ^ 8'(8'h40 + s)}, {24'h0, st[15:8]});
    end
    $display("test stretch_sweep done");

    wr(cctdp_pkg::IDX_CLKCTL, 32'h0000_0001);
    wr(cctdp_pkg::IDX_PRIM, 32'h0000_1234);
    wr(cctdp_pkg::IDX_SEC, 32'h0000_5678);
    wr(cctdp_pkg::IDX_OPND, 32'h0000_003C);
    for (int s = 0; s < 2; s++) begin
      wr(cctdp_pkg::IDX_SELECT, 32'(s));
      run(ins(4'h0, 1'b1, 2'h2, 1'b0, 2'h1, 8'h00));
      chk("ptr_addr", s ? 32'h0000_5678 : 32'h0000_1234, {16'h0, seen_addr});
      chk("ptr_wdata", 32'h0000_003C, {24'h0, seen_wdata});
      rd(cctdp_pkg::IDX_ACTIVE);
      chk("active_ptr", s ? 32'h0000_5678 : 32'h0000_1234, rv & 32'h0000_FFFF);
    end
    run(ins(4'h0, 1'b0, 2'h3, 1'b0, 2'h1, 8'h08));
    rd(cctdp_pkg::IDX_SELECT);
    chk("inc_toggle", 32'h0000_0000, rv);
    run(ins(4'h0, 1'b0, 2'h3, 1'b0, 2'h1, 8'h08));
    rd(cctdp_pkg::IDX_SELECT);
    chk("inc_toggle", 32'h0000_0001, rv);
    wr(cctdp_pkg::IDX_SELECT, 32'h0000_00FE);
    rd(cctdp_pkg::IDX_SELECT);
    chk("select_upper", 32'h0000_0000, rv);
    $display("test dual_pointer done");

    cyc_ins[0] = ins(4'h0, 1'b0, 2'h0, 1'b0, 2'h1, 8'h08); cyc_exp[0] = 4'h1;
    cyc_ins[1] = ins(4'h0, 1'b0, 2'h0, 1'b0, 2'h2, 8'h00); cyc_exp[1] = 4'h2;
    cyc_ins[2] = ins(4'h0, 1'b0, 2'h0, 1'b1, 2'h3, 8'h00); cyc_exp[2] = 4'h4;
    cyc_ins[3] = ins(4'h4, 1'b0, 2'h0, 1'b0, 2'h1, 8'h00); cyc_exp[3] = 4'h5;
    cyc_ins[4] = ins(4'h0, 1'b0, 2'h0, 1'b0, 2'h3, 8'h00); cyc_exp[4] = 4'h3;
    for (int i = 0; i < 5; i++) begin
      run(cyc_ins[i]);
      chk("cycle_count", {28'h0, cyc_exp[i]}, {28'h0, st[7:4]});
      chk("fetch_count", {30'h0, cyc_ins[i][9:8]}, 32'(fetches));
    end
    $display("test cycle_counts done");

    wr(cctdp_pkg::IDX_OPND, 32'h0000_01FF);
    run(ins(4'h1, 1'b0, 2'h0, 1'b0, 2'h1, 8'h08));
    rd(cctdp_pkg::IDX_FLAGS);
    chk("add_flags", 32'h0000_0003, rv & 32'h0000_0007);
    run(ins(4'h4, 1'b0, 2'h0, 1'b0, 2'h1, 8'h08));
    rd(cctdp_pkg::IDX_FLAGS);
    chk("mul_flags", 32'h0000_0000, rv & 32'h0000_0005);
    run(ins(4'h9, 1'b0, 2'h0, 1'b0, 2'h1, 8'h08));
    rd(cctdp_pkg::IDX_FLAGS);
    chk("setc", 32'h0000_0001, rv & 32'h0000_0001);
    run(ins(4'hA, 1'b0, 2'h0, 1'b0, 2'h1, 8'h08));
    rd(cctdp_pkg::IDX_FLAGS);
    chk("clrc", 32'h0000_0000, rv & 32'h0000_0001);
    wr(cctdp_pkg::IDX_OPND, 32'h0000_0201);
    run(ins(4'hF, 1'b0, 2'h0, 1'b0, 2'h1, 8'h08));
    rd(cctdp_pkg::IDX_FLAGS);
    chk("compare_jump_not_equal_carry", 32'h0000_0001, rv & 32'h0000_0001);
    run(ins(4'h3, 1'b0, 2'h0, 1'b0, 2'h1, 8'h08));
    rd(cctdp_pkg::IDX_FLAGS);
    chk("subtract_with_borrow_flags", 32'h0000_0003, rv & 32'h0000_0007);
    run(ins(4'h5, 1'b0, 2'h0, 1'b0, 2'h1, 8'h08));
    rd(cctdp_pkg::IDX_FLAGS);
    chk("div_flags", 32'h0000_0002, rv & 32'h0000_0007);
    run(ins(4'h7, 1'b0, 2'h0, 1'b0, 2'h1, 8'h08));
    rd(cctdp_pkg::IDX_FLAGS);
    chk("rrc_carry", 32'h0000_0003, rv & 32'h0000_0007);
    run(ins(4'hB, 1'b0, 2'h0, 1'b0, 2'h1, 8'h08));
    rd(cctdp_pkg::IDX_FLAGS);
    chk("cplc_carry", 32'h0000_0002, rv & 32'h0000_0007);
    $display("test flags done");
    tally_and_finish();
  end
endmodule
